// [src/phy_fiber_ctrl_regs.sv]
`timescale 1ns/1ns
module phy_fiber_ctrl_regs
#(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // Management pins
  input  wire logic                        mdc,
  input  wire logic                        mdio_in,
  output logic                             mdio_out,
  output logic                             mdio_oe,
  // Strap pin
  input  wire logic                        autoneg_strap_setting,
  // Datapath events and status
  input  wire logic                        false_carrier_evt,
  input  wire logic                        symbol_error_evt,
  input  wire logic                        port_int_active,
  input  wire phy_fiber_pkg::fiber_status_t fiber_status,
  // Fiber controls
  output logic                             fiber_sw_reset,
  output logic                             autoneg_restart,
  output logic                             autoneg_active,
  output logic                             loopback_en,
  output logic [1:0]                       loopback_speed,
  output logic                             link_break,
  output logic                             power_down,
  output logic                             duplex_full
);
  import phy_fiber_pkg::*;

  // Pin synchronisers and filtered levels
  logic [2:0]  mdc_s;
  logic [2:0]  mdio_s;
  logic [2:0]  strap_s;
  logic        mdc_f;
  logic        mdio_f;
  logic        strap_f;
  logic        next_mdc_f;
  logic        next_mdio_f;
  logic        next_strap_f;
  logic        mdc_rise;

  // Management frame state
  mgmt_state_t state;
  mgmt_state_t next_state;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [11:0] hdr;
  logic [11:0] next_hdr;
  logic [15:0] shreg;
  logic [15:0] next_shreg;
  logic        next_mdio_out;
  logic        next_mdio_oe;
  logic        wr_stb;
  logic        next_wr_stb;
  logic        rd_stb;
  logic [4:0]  regad;
  logic        is_read;
  logic        is_me;

  // Register state
  logic [7:0]  page;
  logic [7:0]  next_page;
  logic [15:0] rx_err;
  logic [15:0] next_rx_err;
  fiber_ctrl_t ctrl;
  fiber_ctrl_t next_ctrl;
  logic        reset_busy;
  logic        next_reset_busy;
  logic        restart_bit;
  logic        next_restart_bit;
  logic        duplex_eff;
  logic        next_duplex_eff;
  logic [1:0]  strap_cnt;
  logic [1:0]  next_strap_cnt;
  logic        strap_done;
  logic        next_strap_done;
  logic [15:0] rd_data;
  logic [1:0]  speed_pair;
  logic        sw_reset_start;
  logic        wr_ctrl;
  logic [15:0] wdata;
  logic [17:0] err_sum;

  // Filtered pin levels change only when the later two stages agree
  always_comb begin
    next_mdc_f   = (mdc_s[1] == mdc_s[2]) ? mdc_s[2] : mdc_f;
    next_mdio_f  = (mdio_s[1] == mdio_s[2]) ? mdio_s[2] : mdio_f;
    next_strap_f = (strap_s[1] == strap_s[2]) ? strap_s[2] : strap_f;
    mdc_rise     = ~mdc_f & next_mdc_f;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_s   <= 3'h0;
      mdio_s  <= 3'h7;
      strap_s <= 3'h0;
      mdc_f   <= 1'b0;
      mdio_f  <= 1'b1;
      strap_f <= 1'b0;
    end else begin
      mdc_s   <= {mdc_s[1:0], mdc};
      mdio_s  <= {mdio_s[1:0], mdio_in};
      strap_s <= {strap_s[1:0], autoneg_strap_setting};
      mdc_f   <= next_mdc_f;
      mdio_f  <= next_mdio_f;
      strap_f <= next_strap_f;
    end
  end

  // Header fields of the frame in progress
  assign is_read = (hdr[11:10] == OP_READ);
  assign is_me   = (hdr[9:5] == PHY_ADDR);
  assign regad   = hdr[4:0];

  // Management frame sequencer, one step per rising edge of the clock pin
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_hdr      = hdr;
    next_shreg    = shreg;
    next_mdio_out = mdio_out;
    next_mdio_oe  = mdio_oe;
    next_wr_stb   = 1'b0;
    rd_stb        = 1'b0;
    if (mdc_rise) begin
      unique case (state)
        ST_IDLE: begin
          next_state = mdio_f ? ST_IDLE : ST_START;
        end
        ST_START: begin
          next_state = mdio_f ? ST_HDR : ST_IDLE;
          next_cnt   = 4'd0;
        end
        ST_HDR: begin
          next_hdr = {hdr[10:0], mdio_f};
          next_cnt = cnt + 4'd1;
          if (cnt == HDR_LAST) begin
            next_cnt   = 4'd0;
            next_state = ST_TA;
          end
        end
        ST_TA: begin
          next_cnt = cnt + 4'd1;
          if (!is_me || (hdr[11:10] != OP_READ
                         && hdr[11:10] != OP_WRITE)) begin
            next_state = ST_IDLE;
          end else if (cnt == 4'd0) begin
            next_mdio_oe  = is_read;
            next_mdio_out = 1'b0;
            next_shreg    = rd_data;
            rd_stb        = is_read;
          end else begin
            next_cnt      = 4'd0;
            next_state    = is_read ? ST_RDATA : ST_WDATA;
            next_mdio_out = is_read & shreg[15];
            next_shreg    = {shreg[14:0], 1'b0};
          end
        end
        ST_RDATA: begin
          next_cnt      = cnt + 4'd1;
          next_mdio_out = shreg[15];
          next_shreg    = {shreg[14:0], 1'b0};
          if (cnt == DATA_LAST) begin
            next_mdio_oe  = 1'b0;
            next_mdio_out = 1'b0;
            next_state    = ST_IDLE;
          end
        end
        ST_WDATA: begin
          next_cnt   = cnt + 4'd1;
          next_shreg = {shreg[14:0], mdio_f};
          if (cnt == DATA_LAST) begin
            next_wr_stb = 1'b1;
            next_state  = ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      cnt      <= 4'd0;
      hdr      <= 12'h000;
      shreg    <= 16'h0000;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
      wr_stb   <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      hdr      <= next_hdr;
      shreg    <= next_shreg;
      mdio_out <= next_mdio_out;
      mdio_oe  <= next_mdio_oe;
      wr_stb   <= next_wr_stb;
    end
  end

  // Speed pair as read back and as used by loopback
  always_comb begin
    unique case (fiber_status.mode)
      MODE_100FX:   speed_pair = SPEED_100;
      MODE_1000X:   speed_pair = SPEED_1000;
      MODE_SGMII_A: speed_pair = {fiber_status.at_1000,
                                  fiber_status.at_100};
      MODE_SGMII_B: speed_pair = {ctrl.speed_msb, ctrl.speed_lsb};
    endcase
  end

  // Read mux; isolate, collision test and reserved bits stay zero
  always_comb begin
    rd_data = 16'h0000;
    if (regad == REG_PAGE_ADDRESS) begin
      rd_data[7:0] = page;
    end else if (page == PAGE_COPPER && regad == REG_RX_ERROR_COUNT) begin
      rd_data = rx_err;
    end else if (page == PAGE_COPPER && regad == REG_GLOBAL_INT) begin
      rd_data[0] = port_int_active;
    end else if (page == PAGE_FIBER && regad == REG_FIBER_CONTROL) begin
      rd_data[BIT_FIBER_RESET] = reset_busy;
      rd_data[BIT_LOOPBACK]    = ctrl.loopback;
      rd_data[BIT_SPEED_LSB]   = speed_pair[0];
      rd_data[BIT_AN_ENABLE]   = ctrl.an_enable;
      rd_data[BIT_POWER_DOWN]  = ctrl.power_down;
      rd_data[BIT_AN_RESTART]  = restart_bit;
      rd_data[BIT_DUPLEX]      = ctrl.duplex;
      rd_data[BIT_SPEED_MSB]   = speed_pair[1];
    end
  end

  // Register updates and fiber control sequencing
  always_comb begin
    wdata            = shreg;
    wr_ctrl          = wr_stb && page == PAGE_FIBER
                       && regad == REG_FIBER_CONTROL;
    next_page        = (wr_stb && regad == REG_PAGE_ADDRESS)
                       ? wdata[7:0] : page;
    next_ctrl        = ctrl;
    next_reset_busy  = reset_busy;
    next_restart_bit = 1'b0;
    next_duplex_eff  = duplex_eff;
    next_strap_cnt   = strap_cnt;
    next_strap_done  = strap_done;
    sw_reset_start   = 1'b0;
    // Error counter: read clears, events added afterwards and saturate
    err_sum = {2'b00, (rd_stb && page == PAGE_COPPER
                       && regad == REG_RX_ERROR_COUNT)
                      ? RST_RX_ERROR_COUNT : rx_err}
              + {17'h00000, false_carrier_evt}
              + {17'h00000, symbol_error_evt};
    next_rx_err = (err_sum > {2'b00, RX_ERROR_MAX})
                  ? RX_ERROR_MAX : err_sum[15:0];
    if (wr_ctrl) begin
      next_ctrl.loopback   = wdata[BIT_LOOPBACK];
      next_ctrl.an_enable  = wdata[BIT_AN_ENABLE];
      next_ctrl.power_down = wdata[BIT_POWER_DOWN];
      next_ctrl.duplex     = wdata[BIT_DUPLEX];
      if (fiber_status.mode == MODE_SGMII_B) begin
        next_ctrl.speed_lsb = wdata[BIT_SPEED_LSB];
        next_ctrl.speed_msb = wdata[BIT_SPEED_MSB];
      end
      sw_reset_start = wdata[BIT_FIBER_RESET]
                       || (ctrl.power_down
                           && !wdata[BIT_POWER_DOWN]);
      if (wdata[BIT_AN_RESTART]
          || wdata[BIT_AN_ENABLE] != ctrl.an_enable) begin
        next_restart_bit = 1'b1;
      end
    end
    // Strap is taken once it has settled after reset release
    if (!strap_done) begin
      next_strap_cnt = strap_cnt + 2'd1;
      if (strap_cnt == STRAP_WAIT) begin
        next_ctrl.an_enable = next_strap_f;
        next_strap_done     = 1'b1;
        next_restart_bit    = 1'b1;
      end
    end
    if (sw_reset_start) begin
      next_reset_busy      = 1'b1;
      next_restart_bit     = 1'b1;
      next_ctrl.loopback   = 1'b0;
      next_ctrl.power_down = 1'b0;
    end else if (reset_busy && fiber_status.reset_done) begin
      next_reset_busy = 1'b0;
    end
    if (next_restart_bit) begin
      next_duplex_eff = next_ctrl.duplex;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      page        <= RST_PAGE;
      rx_err      <= RST_RX_ERROR_COUNT;
      ctrl        <= '{loopback: 1'b0, speed_lsb: RST_SPEED_LSB,
                       an_enable: 1'b0, power_down: 1'b0,
                       duplex: RST_DUPLEX, speed_msb: RST_SPEED_MSB};
      reset_busy  <= 1'b0;
      restart_bit <= 1'b0;
      duplex_eff  <= RST_DUPLEX;
      strap_cnt   <= 2'd0;
      strap_done  <= 1'b0;
    end else begin
      page        <= next_page;
      rx_err      <= next_rx_err;
      ctrl        <= next_ctrl;
      reset_busy  <= next_reset_busy;
      restart_bit <= next_restart_bit;
      duplex_eff  <= next_duplex_eff;
      strap_cnt   <= next_strap_cnt;
      strap_done  <= next_strap_done;
    end
  end

  // Registered controls toward the fiber datapath
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fiber_sw_reset  <= 1'b0;
      autoneg_restart <= 1'b0;
      autoneg_active  <= 1'b0;
      loopback_en     <= 1'b0;
      loopback_speed  <= SPEED_10;
      link_break      <= 1'b1;
      power_down      <= 1'b0;
      duplex_full     <= RST_DUPLEX;
    end else begin
      fiber_sw_reset  <= next_reset_busy;
      autoneg_restart <= next_restart_bit;
      autoneg_active  <= next_ctrl.an_enable
                         && fiber_status.mode != MODE_100FX;
      loopback_en     <= next_ctrl.loopback;
      loopback_speed  <= speed_pair;
      link_break      <= next_ctrl.loopback || next_restart_bit
                         || next_reset_busy
                         || next_ctrl.power_down;
      power_down      <= next_ctrl.power_down;
      duplex_full     <= next_duplex_eff;
    end
  end

endmodule

// [src/phy_fiber_pkg.sv]
package phy_fiber_pkg;

  // Register numbers and page numbers
  localparam logic [4:0] REG_FIBER_CONTROL  = 5'h00;
  localparam logic [4:0] REG_RX_ERROR_COUNT = 5'h15;
  localparam logic [4:0] REG_PAGE_ADDRESS   = 5'h16;
  localparam logic [4:0] REG_GLOBAL_INT     = 5'h17;
  localparam logic [7:0] PAGE_COPPER        = 8'h00;
  localparam logic [7:0] PAGE_FIBER         = 8'h01;

  // Field positions of the fiber control register
  localparam int BIT_FIBER_RESET = 15;
  localparam int BIT_LOOPBACK    = 14;
  localparam int BIT_SPEED_LSB   = 13;
  localparam int BIT_AN_ENABLE   = 12;
  localparam int BIT_POWER_DOWN  = 11;
  localparam int BIT_AN_RESTART  = 9;
  localparam int BIT_DUPLEX      = 8;
  localparam int BIT_SPEED_MSB   = 6;

  // Reset values and error counter ceiling
  localparam logic [15:0] RST_RX_ERROR_COUNT = 16'h0000;
  localparam logic [15:0] RX_ERROR_MAX       = 16'hFFFF;
  localparam logic [7:0]  RST_PAGE           = 8'h00;
  localparam logic        RST_DUPLEX         = 1'b1;
  localparam logic        RST_SPEED_MSB      = 1'b1;
  localparam logic        RST_SPEED_LSB      = 1'b0;

  // Interface modes
  localparam logic [1:0] MODE_100FX   = 2'b00;
  localparam logic [1:0] MODE_1000X   = 2'b01;
  localparam logic [1:0] MODE_SGMII_A = 2'b10;
  localparam logic [1:0] MODE_SGMII_B = 2'b11;

  // Speed codes, high bit then low bit
  localparam logic [1:0] SPEED_1000 = 2'b10;
  localparam logic [1:0] SPEED_100  = 2'b01;
  localparam logic [1:0] SPEED_10   = 2'b00;

  // Management frame fields, sequencer states and strap wait
  localparam logic [1:0] OP_READ     = 2'b10;
  localparam logic [1:0] OP_WRITE    = 2'b01;
  localparam logic [3:0] HDR_LAST    = 4'd11;
  localparam logic [3:0] DATA_LAST   = 4'd15;
  localparam logic [1:0] STRAP_WAIT  = 2'd3;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_START = 6'b000010,
    ST_HDR   = 6'b000100,
    ST_TA    = 6'b001000,
    ST_RDATA = 6'b010000,
    ST_WDATA = 6'b100000
  } mgmt_state_t;

  // Writable state of the fiber control register
  typedef struct packed {
    logic loopback;
    logic speed_lsb;
    logic an_enable;
    logic power_down;
    logic duplex;
    logic speed_msb;
  } fiber_ctrl_t;

  // Status fed in from the fiber datapath
  typedef struct packed {
    logic [1:0] mode;
    logic       at_1000;
    logic       at_100;
    logic       reset_done;
  } fiber_status_t;

endpackage

// [verif/mgmt_master_model.sv]
`timescale 1ns/1ns
// Station manager: frames on the management pins, clock still when idle
module mgmt_master_model
  import phy_fiber_pkg::*;
#(
  parameter int HALF = 8
) (
  // Reference clock and resolved data line
  input  wire logic ref_clk,
  input  wire logic mdio_wire,
  // Management clock and data drive
  output logic      mdc,
  output logic      m_oe,
  output logic      m_out
);
  // Idle: clock low, data released to the pull-up
  initial begin
    mdc = 1'b0;
    m_oe = 1'b0;
    m_out = 1'b0;
  end

  // Steps just past a reference edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // One frame; data is set while the clock is low, read just before rises
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [31:0] bits;
    bits = {2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      m_oe = (op == OP_WRITE) || (i < 14);
      m_out = bits[31-i];
      step(HALF);
      if (i >= 16) rd = {rd[14:0], mdio_wire};
      mdc = 1'b1;
      step(HALF);
      mdc = 1'b0;
    end
    m_oe = 1'b0;
    step(2 * HALF);
  endtask
endmodule

// [verif/phy_fiber_ctrl_regs_chk.sv]
`timescale 1ns/1ns
// Port checks of the fiber control bank
module phy_fiber_ctrl_regs_chk
  import phy_fiber_pkg::*;
(
  // Clock, reset and pins
  input wire logic                          ref_clk,
  input wire logic                          rst_n,
  input wire logic                          mdc,
  input wire logic                          mdio_in,
  input wire logic                          mdio_out,
  input wire logic                          mdio_oe,
  input wire logic                          autoneg_strap_setting,
  // Datapath side
  input wire logic                          false_carrier_evt,
  input wire logic                          symbol_error_evt,
  input wire logic                          port_int_active,
  input wire phy_fiber_pkg::fiber_status_t  fiber_status,
  input wire logic                          fiber_sw_reset,
  input wire logic                          autoneg_restart,
  input wire logic                          autoneg_active,
  input wire logic                          loopback_en,
  input wire logic [1:0]                    loopback_speed,
  input wire logic                          link_break,
  input wire logic                          power_down,
  input wire logic                          duplex_full
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Link and reset behaviour
  property p_lb_break; loopback_en |-> ##[0:1] link_break; endproperty
  a_lb_break: assert property (p_lb_break) else $error("link kept");
  property p_rst_hold;
    fiber_sw_reset && !fiber_status.reset_done |=> fiber_sw_reset;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset early");
  property p_rst_an; $rose(fiber_sw_reset) |-> ##[0:12] autoneg_restart;
  endproperty
  a_rst_an: assert property (p_rst_an) else $error("no restart");
  property p_pd_exit; $fell(power_down) |-> ##[0:12] autoneg_restart;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("wake no restart");
  property p_an_pulse; autoneg_restart |=> !autoneg_restart; endproperty
  a_an_pulse: assert property (p_an_pulse) else $error("restart stuck");
  // Speed, mode, duplex and turnaround
  property p_fx_speed;
    (fiber_status.mode == MODE_100FX) [*4] |-> loopback_speed == SPEED_100;
  endproperty
  a_fx_speed: assert property (p_fx_speed) else $error("fx speed");
  property p_x_speed;
    (fiber_status.mode == MODE_1000X) [*4] |-> loopback_speed == SPEED_1000;
  endproperty
  a_x_speed: assert property (p_x_speed) else $error("gig speed");
  property p_fx_an;
    (fiber_status.mode == MODE_100FX) [*4] |-> !autoneg_active;
  endproperty
  a_fx_an: assert property (p_fx_an) else $error("fx autoneg");
  property p_dup;
    $changed(duplex_full) |-> autoneg_restart || $past(autoneg_restart);
  endproperty
  a_dup: assert property (p_dup) else $error("duplex moved");
  property p_oe_ta; $rose(mdio_oe) |-> !mdio_out; endproperty
  a_oe_ta: assert property (p_oe_ta) else $error("turnaround");
endmodule

bind phy_fiber_ctrl_regs phy_fiber_ctrl_regs_chk i_phy_fiber_ctrl_regs_chk (
  .ref_clk, .rst_n, .mdc, .mdio_in, .mdio_out, .mdio_oe,
  .autoneg_strap_setting, .false_carrier_evt, .symbol_error_evt,
  .port_int_active, .fiber_status, .fiber_sw_reset, .autoneg_restart,
  .autoneg_active, .loopback_en, .loopback_speed, .link_break,
  .power_down, .duplex_full);

// [verif/phy_fiber_ctrl_regs_tb_top.sv]
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD %s exp %h got %h", nm, e, g); end end
module phy_fiber_ctrl_regs_tb_top;
  import phy_fiber_pkg::*;
  localparam logic [4:0] PHY = 5'h00;
  // Pins and status
  logic          ref_clk, rst_n, mdc, m_oe, m_out, mdio_wire;
  logic          mdio_out, mdio_oe, strap, fc, sym, port_int;
  logic [1:0]    mode, loopback_speed;
  logic          at_1000, at_100, rst_done;
  fiber_status_t fs;
  logic          fiber_sw_reset, autoneg_restart, autoneg_active;
  logic          loopback_en, link_break, power_down, duplex_full;
  logic [2:0]    busy_cnt = 3'h0;
  logic [15:0]   rd;
  int            miscompares, num_checks;
  int            n_restart = 0;
  int            n_rst_cyc = 0;

  // Pull-up on the shared data line
  assign mdio_wire = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1);
  assign fs = {mode, at_1000, at_100, rst_done};
  assign rst_done = (busy_cnt == 3'h4);

  // Fiber datapath stand-in: reset completes after four cycles
  always @(posedge ref_clk) begin
    busy_cnt <= fiber_sw_reset ? busy_cnt + 3'h1 : 3'h0;
    if (autoneg_restart === 1'b1) n_restart <= n_restart + 1;
    if (fiber_sw_reset === 1'b1) n_rst_cyc <= n_rst_cyc + 1;
  end

  phy_fiber_ctrl_regs #(.PHY_ADDR(PHY)) i_phy_fiber_ctrl_regs (
    .ref_clk(ref_clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_wire),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .autoneg_strap_setting(strap),
    .false_carrier_evt(fc), .symbol_error_evt(sym),
    .port_int_active(port_int), .fiber_status(fs),
    .fiber_sw_reset(fiber_sw_reset), .autoneg_restart(autoneg_restart),
    .autoneg_active(autoneg_active), .loopback_en(loopback_en),
    .loopback_speed(loopback_speed), .link_break(link_break),
    .power_down(power_down), .duplex_full(duplex_full));

  mgmt_master_model i_mgmt_master_model (
    .ref_clk(ref_clk), .mdio_wire(mdio_wire), .mdc(mdc), .m_oe(m_oe),
    .m_out(m_out));

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    i_mgmt_master_model.xfer(OP_WRITE, PHY, ra, d, rd);
  endtask

  task automatic rdchk(input string nm, input logic [4:0] ra,
                       input logic [15:0] e);
    i_mgmt_master_model.xfer(OP_READ, PHY, ra, 16'h0000, rd);
    `CHK(nm, e, rd)
  endtask

  // Reset values, page register and interrupt summary
  task automatic t_reset();
    rdchk("page_rst", REG_PAGE_ADDRESS, 16'h0000);
    rdchk("int_off", REG_GLOBAL_INT, 16'h0000);
    port_int = 1'b1;
    step(2);
    rdchk("int_on", REG_GLOBAL_INT, 16'h0001);
    port_int = 1'b0;
    wr(REG_PAGE_ADDRESS, 16'hFFFF);
    rdchk("page_rsv", REG_PAGE_ADDRESS, 16'h00FF);
    wr(REG_PAGE_ADDRESS, {8'h00, PAGE_FIBER});
    rdchk("page_any", REG_PAGE_ADDRESS, 16'h0001);
    rdchk("ctl_rst", REG_FIBER_CONTROL, 16'h1140);
    `CHK("hw_restart", 1, n_restart)
    `CHK("an_act", 1'b1, autoneg_active)
  endtask

  // Control writes, read-only bits, duplex timing, resets
  task automatic t_ctrl();
    int r0;
    wr(REG_FIBER_CONTROL, 16'h7FFF);
    rdchk("ctl_ro", REG_FIBER_CONTROL, 16'h7940);
    `CHK("lb_en", 1'b1, loopback_en)
    `CHK("lb_brk", 1'b1, link_break)
    `CHK("lb_spd", 2'b11, loopback_speed)
    `CHK("pd", 1'b1, power_down)
    wr(REG_FIBER_CONTROL, 16'h7840);
    `CHK("dup_hold", 1'b1, duplex_full)
    r0 = n_restart;
    wr(REG_FIBER_CONTROL, 16'h3040);
    `CHK("wake_an", 1, n_restart - r0)
    `CHK("wake_dup", 1'b0, duplex_full)
    `CHK("wake_rst", 1'b1, n_rst_cyc > 0)
    r0 = n_rst_cyc;
    wr(REG_FIBER_CONTROL, 16'hB140);
    rdchk("rst_sc", REG_FIBER_CONTROL, 16'h3140);
    `CHK("rst_seen", 1'b1, n_rst_cyc > r0)
    `CHK("rst_done", 1'b0, fiber_sw_reset)
    `CHK("rst_dup", 1'b1, duplex_full)
    `CHK("lb_off", 1'b0, link_break)
    `CHK("lb_clr", 1'b0, loopback_en)
  endtask

  // Enable changes restart in MODE_SGMII_B and MODE_100FX, idle in 100 fiber mode
  task automatic t_aneg();
    int r0;
    r0 = n_restart;
    wr(REG_FIBER_CONTROL, 16'h2140);
    `CHK("en_off", 1, n_restart - r0)
    `CHK("an_off", 1'b0, autoneg_active)
    mode = MODE_100FX;
    step(4);
    wr(REG_FIBER_CONTROL, 16'h3140);
    `CHK("en_fx", 2, n_restart - r0)
    `CHK("an_fx", 1'b0, autoneg_active)
  endtask

  // Speed bits per interface mode
  task automatic t_modes();
    logic [1:0]  md [5] = '{MODE_100FX, MODE_1000X, MODE_SGMII_A,
                            MODE_SGMII_A, MODE_SGMII_A};
    logic [15:0] ex [5] = '{16'h3100, 16'h1140, 16'h1140, 16'h3100,
                            16'h1100};
    logic [1:0]  sp [5] = '{SPEED_100, SPEED_1000, SPEED_1000, SPEED_100,
                            SPEED_10};
    for (int k = 0; k < 5; k++) begin
      mode = md[k];
      at_1000 = (k == 2);
      at_100 = (k == 3);
      step(4);
      rdchk("spd_rd", REG_FIBER_CONTROL, ex[k]);
      `CHK("spd_lb", sp[k], loopback_speed)
    end
    mode = MODE_SGMII_B;
  endtask

  // Other address and unmapped register
  task automatic t_refused();
    i_mgmt_master_model.xfer(OP_READ, PHY + 5'h1, 5'h00, 16'h0000, rd);
    `CHK("phy_other", 16'hFFFF, rd)
    wr(REG_PAGE_ADDRESS, {8'h00, PAGE_COPPER});
    rdchk("unmapped", 5'h05, 16'h0000);
  endtask

  // Error counting, both sources, saturation and clear on read
  task automatic t_counter();
    for (int i = 0; i < 6; i++) begin
      fc = (i < 5);
      sym = (i >= 3);
      step(1);
      fc = 1'b0;
      sym = 1'b0;
      step(1);
    end
    rdchk("cnt_both", REG_RX_ERROR_COUNT, 16'h0008);
    rdchk("cnt_clr", REG_RX_ERROR_COUNT, 16'h0000);
    repeat (32768) begin
      fc = 1'b1;
      sym = 1'b1;
      step(1);
      fc = 1'b0;
      sym = 1'b0;
      step(1);
    end
    rdchk("cnt_peg", REG_RX_ERROR_COUNT, RX_ERROR_MAX);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    strap = 1'b1;
    fc = 1'b0;
    sym = 1'b0;
    port_int = 1'b0;
    mode = MODE_SGMII_B;
    at_1000 = 1'b0;
    at_100 = 1'b0;
    miscompares = 0;
    num_checks = 0;
    repeat (8) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    step(12);
    t_reset();
    t_ctrl();
    t_aneg();
    t_modes();
    t_refused();
    t_counter();
    tally_and_finish();
  end
endmodule
